/* logic/scx_pkg.sv */
// What this block does
// - Top slice: negative pulls propagate/negative low.
// - Top slice: signed overflow pulls generate/overflow low.
// - Carry, propagate, generate outputs are ungated.
// - Lower slice arithmetic: show propagate and generate.
// - Arithmetic: bit zero is the carry in.
// - Arithmetic exactly when bits one, two low.
// - Arithmetic: carry-out pin shows slice carry.
// - Lower slice logic op: propagate low, generate high.
// - Top slice shows negative and overflow status.
// - Bit zero is lowest, ascending to top.
// - Logic op: carry-out pin follows bit zero.
// - Only add types use carry; bit0 low adds one.
`default_nettype none
package scx_pkg;
  localparam int SCX_WIDTH = 4;
  localparam logic [2:0] SCX_RESET_INSTR = 3'h1;
  localparam logic [3:0] SCX_RESET_DATA = 4'hF;
  localparam int SCX_SYNC_STAGES = 3;

  typedef struct packed {
    logic carry_out_n;
    logic prop_neg_n;
    logic gen_ovf_n;
  } scx_flags_type;
endpackage : scx_pkg
`default_nettype wire

/* logic/scx_sync.sv */
`default_nettype none
module scx_sync
  import scx_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // ----------------------------------------------------------------
  // Three-stage capture with agreement filter
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A synchroniser without bits cannot be built.
  if (WIDTH < 1)
  begin : g_bad_width
    $error("scx_sync width must be positive.");
  end

  // The filtered value only moves once stages two and three agree.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i]) dout[i] <= stage3[i];
      end
    end
  end
endmodule : scx_sync
`default_nettype wire

/* logic/scx_slice.sv */
`default_nettype none
module scx_slice
  import scx_pkg::*;
#(
  parameter int WIDTH = SCX_WIDTH
)
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SLICE_TOP_SELECT,
  input wire logic INSTR_BIT0_CARRY_IN,
  input wire logic INSTR_BIT1,
  input wire logic INSTR_BIT2,
  input wire logic [WIDTH-1:0] OPERAND_IN_N,
  input wire logic [WIDTH-1:0] REG_OPERAND,
  output logic CARRY_OUT_N,
  output logic PROP_NEG_N,
  output logic GEN_OVF_N,
  output logic [WIDTH-1:0] SUM
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The sign and overflow terms need a sign bit above at least one data bit.
  if (WIDTH < 2)
  begin : g_bad_width
    $error("Slice width must be at least two bits.");
  end

  // ----------------------------------------------------------------
  // Check clocking
  // ----------------------------------------------------------------
  // Every check below samples on the reference clock and rests while reset is high.
  default clocking check_clk @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic [2:0] instr;
  logic top_sel;
  logic [WIDTH-1:0] opd_n;
  logic [WIDTH-1:0] reg_a;

  // Pin inputs pass a three-stage filter before use.
  scx_sync #(.WIDTH(3), .INIT(SCX_RESET_INSTR)) u_sync_instr
  (
    .clk(REF_CLK),
    .srst(SRST),
    .din({INSTR_BIT2, INSTR_BIT1, INSTR_BIT0_CARRY_IN}),
    .dout(instr)
  );

  // The slice position select idles low, as on every slice but the top one.
  scx_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_top
  (
    .clk(REF_CLK),
    .srst(SRST),
    .din(SLICE_TOP_SELECT),
    .dout(top_sel)
  );

  // The active-low operand idles at all ones.
  scx_sync #(.WIDTH(WIDTH), .INIT({WIDTH{1'b1}})) u_sync_opd
  (
    .clk(REF_CLK),
    .srst(SRST),
    .din(OPERAND_IN_N),
    .dout(opd_n)
  );

  // The register operand stands in for the stored word and idles at zero.
  scx_sync #(.WIDTH(WIDTH), .INIT('0)) u_sync_reg
  (
    .clk(REF_CLK),
    .srst(SRST),
    .din(REG_OPERAND),
    .dout(reg_a)
  );

  // ----------------------------------------------------------------
  // Adder and carry terms
  // ----------------------------------------------------------------
  // Operand bit zero is the lowest-order bit of the slice.
  wire [WIDTH-1:0] opd_b = ~opd_n;
  wire is_arith = ~instr[1] & ~instr[2];
  // Bit zero low adds one; it serves as carry in for add types.
  wire carry_in = ~instr[0];
  wire [WIDTH:0] add_full = {1'b0, reg_a} + {1'b0, opd_b} + {{WIDTH{1'b0}}, carry_in};
  wire [WIDTH-1:0] add_res = add_full[WIDTH-1:0];
  wire slice_carry = add_full[WIDTH];
  wire [WIDTH-1:0] p_bits = reg_a | opd_b;
  wire [WIDTH-1:0] g_bits = reg_a & opd_b;

  // Group propagate and generate built bit by bit.
  logic [WIDTH-1:0] grp_p;
  logic [WIDTH-1:0] grp_g;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_la
      if (gi == 0)
      begin : g_first
        assign grp_p[gi] = p_bits[gi];
        assign grp_g[gi] = g_bits[gi];
      end
      else
      begin : g_next
        assign grp_p[gi] = grp_p[gi-1] & p_bits[gi];
        assign grp_g[gi] = g_bits[gi] | (p_bits[gi] & grp_g[gi-1]);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result for the arithmetic and logic operations
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] result;
  always_comb
  begin
    case (instr)
      3'h0, 3'h1: result = add_res;
      3'h2: result = reg_a & opd_b;
      3'h3: result = opd_b;
      3'h4: result = reg_a;
      3'h5: result = reg_a | opd_b;
      3'h6: result = reg_a ^ opd_b;
      default: result = opd_n;
    endcase
  end

  // ----------------------------------------------------------------
  // Status and expansion outputs
  // ----------------------------------------------------------------
  wire negative = result[WIDTH-1];
  wire overflow = is_arith & (reg_a[WIDTH-1] == opd_b[WIDTH-1]) & (add_res[WIDTH-1] != reg_a[WIDTH-1]);
  // Top select chooses status; otherwise arithmetic shows lookahead terms.
  wire next_prop_neg_n = top_sel ? ~negative : (is_arith ? ~grp_p[WIDTH-1] : 1'b0);
  wire next_gen_ovf_n = top_sel ? ~overflow : (is_arith ? ~grp_g[WIDTH-1] : 1'b1);
  // Carry-out pin shows slice carry or passes bit zero through.
  wire next_carry_out_n = is_arith ? ~slice_carry : instr[0];

  // The three expansion levels are bundled only for the check against the output register.
  scx_flags_type next_flags;
  assign next_flags = '{carry_out_n: next_carry_out_n, prop_neg_n: next_prop_neg_n, gen_ovf_n: next_gen_ovf_n};

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Outputs are registered once; no execute or slice clock gating applies.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      CARRY_OUT_N <= 1'b1;
      PROP_NEG_N <= 1'b1;
      GEN_OVF_N <= 1'b1;
      SUM <= '0;
    end
    else
    begin
      CARRY_OUT_N <= next_carry_out_n;
      PROP_NEG_N <= next_prop_neg_n;
      GEN_OVF_N <= next_gen_ovf_n;
      SUM <= result;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The top slice shows the inverted sign of the result.
  chk_neg_flag: assert property (top_sel |=> PROP_NEG_N == ~$past(negative))
    else $error("Negative flag wrong on top slice.");

  // A signed overflow on the top slice pulls the flag low.
  chk_ovf_flag: assert property ((top_sel && is_arith && overflow) |=> !GEN_OVF_N)
    else $error("Overflow flag not asserted.");

  // Without an overflow the top slice leaves the flag high.
  chk_ovf_clear: assert property ((top_sel && !overflow) |=> GEN_OVF_N)
    else $error("Overflow flag asserted without overflow.");

  // Each expansion pin follows its next value one clock later, with no hold or gating.
  chk_no_gate: assert property (1'b1 |=> {CARRY_OUT_N, PROP_NEG_N, GEN_OVF_N} == $past(next_flags))
    else $error("Expansion outputs held or gated.");

  // A lower slice in arithmetic shows its group propagate and generate.
  chk_lower_pg: assert property ((!top_sel && is_arith) |=>
    (PROP_NEG_N == ~$past(grp_p[WIDTH-1]) && GEN_OVF_N == ~$past(grp_g[WIDTH-1])))
    else $error("Lookahead terms wrong.");

  // With both operands zero the sum is the carry in alone.
  chk_carry_in: assert property ((is_arith && reg_a == '0 && opd_b == '0) |=>
    SUM == {{(WIDTH-1){1'b0}}, ~$past(instr[0])})
    else $error("Carry in not applied.");

  // An arithmetic code takes the adder result into the sum register.
  chk_arith_dec: assert property ((instr[2:1] == 2'h0) |=> SUM == $past(add_res))
    else $error("Arithmetic decode wrong.");

  // In arithmetic the carry-out pin shows the slice carry.
  chk_carry_out: assert property (is_arith |=> CARRY_OUT_N == ~$past(slice_carry))
    else $error("Carry out wrong.");

  // A lower slice in a logic operation lets lookahead carries pass.
  chk_logic_pass: assert property ((!top_sel && !is_arith) |=> (!PROP_NEG_N && GEN_OVF_N))
    else $error("Pass levels wrong.");

  // The top slice reports no overflow for a logic operation.
  chk_top_status: assert property ((top_sel && !is_arith) |=> GEN_OVF_N)
    else $error("Top status overflow wrong.");

  // In a logic operation the carry-out pin follows bit zero.
  chk_bit0_pass: assert property (!is_arith |=> CARRY_OUT_N == $past(instr[0]))
    else $error("Carry out did not follow bit zero.");

  // Main scenarios: an add with carry, top-slice overflow and sign, and logic pass-through.
  cov_add_carry: cover property (is_arith && slice_carry);
  cov_overflow: cover property (top_sel && overflow);
  cov_negative: cover property (top_sel && negative);
  cov_pass: cover property (!top_sel && !is_arith);
endmodule : scx_slice
`default_nettype wire

/* testbench/scx_nbr_model.sv */
`default_nettype none
// -----------------------------------------------------------------
// Lower neighbour slice feeding the carry-in pin
// -----------------------------------------------------------------
module scx_nbr_model
  import scx_pkg::*;
(
  input wire logic [SCX_WIDTH-1:0] nbr_reg,
  input wire logic [SCX_WIDTH-1:0] nbr_operand_n,
  input wire logic nbr_carry_in_n,
  input wire logic instr_bit1,
  input wire logic instr_bit2,
  output logic carry_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SCX_WIDTH:0] nbr_total;
  logic nbr_arith;
  // The neighbour adds its register to the inverted operand, plus one when its bit zero is low.
  assign nbr_total = {1'b0, nbr_reg} + {1'b0, ~nbr_operand_n} + {{SCX_WIDTH{1'b0}}, ~nbr_carry_in_n};
  assign nbr_arith = ~instr_bit1 & ~instr_bit2;
  // Its top select is tied low, so carry ripples up in arithmetic and bit zero passes otherwise.
  assign carry_out_n = nbr_arith ? ~nbr_total[SCX_WIDTH] : nbr_carry_in_n;
endmodule : scx_nbr_model
`default_nettype wire

/* testbench/scx_slice_tb.sv */
`default_nettype none
module scx_slice_tb
  import scx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, srst, top_sel, bit0, bit1, bit2, nbr_cin_n, carry_out_n, prop_neg_n, gen_ovf_n;
  logic [3:0] operand_n, reg_op, nbr_reg, nbr_op_n, sum;
  logic [7:0] corners [4] = '{8'h7E, 8'hFE, 8'h87, 8'h0F};
  logic [31:0] rnd;
  int seed, n_errors, tests_run;
  // -----------------------------------------------------------------
  // Design, neighbour and clock
  // -----------------------------------------------------------------
  scx_slice dut (.REF_CLK(ref_clk), .SRST(srst), .SLICE_TOP_SELECT(top_sel), .INSTR_BIT0_CARRY_IN(bit0),
    .INSTR_BIT1(bit1), .INSTR_BIT2(bit2), .OPERAND_IN_N(operand_n), .REG_OPERAND(reg_op),
    .CARRY_OUT_N(carry_out_n), .PROP_NEG_N(prop_neg_n), .GEN_OVF_N(gen_ovf_n), .SUM(sum));
  scx_nbr_model nbr (.nbr_reg(nbr_reg), .nbr_operand_n(nbr_op_n), .nbr_carry_in_n(nbr_cin_n),
    .instr_bit1(bit1), .instr_bit2(bit2), .carry_out_n(bit0));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // -----------------------------------------------------------------
  // Prediction and comparison
  // -----------------------------------------------------------------
  // Returns {prop unsure, carry_out_n, prop_neg_n, gen_ovf_n, result}.
  function automatic logic [7:0] predict(input logic top, input logic [2:0] ins, input logic [3:0] r, dn);
    logic [4:0] tot, raw;
    logic [3:0] b, res;
    logic ar, pxor, por, ovf;
    b = ~dn;
    ar = (ins[2:1] == 2'h0);
    tot = {1'b0, r} + {1'b0, b} + {4'h0, ~ins[0]};
    raw = {1'b0, r} + {1'b0, b};
    pxor = &(r ^ b);
    por = &(r | b);
    case (ins)
      3'h2: res = r & b;
      3'h3: res = b;
      3'h4: res = r;
      3'h5: res = r | b;
      3'h6: res = r ^ b;
      3'h7: res = dn;
      default: res = tot[3:0];
    endcase
    ovf = (r[3] == b[3]) && (tot[3] != r[3]);
    return {(pxor != por) & ar & ~top, ar ? ~tot[4] : ins[0], top ? ~res[3] : (ar ? ~pxor : 1'b0),
      top ? ~(ar & ovf) : (ar ? ~raw[4] : 1'b1), res};
  endfunction : predict
  // Counts one comparison and reports a difference.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Drives one operation, waits out the filter latency and compares every output, prop_neg_n only when its prediction is sure.
  task automatic apply(input logic top, input logic [1:0] hi, input logic [3:0] r, input logic [3:0] dn);
    logic [7:0] e;
    @(posedge ref_clk);
    top_sel <= top;
    bit1 <= hi[0];
    bit2 <= hi[1];
    reg_op <= r;
    operand_n <= dn;
    rnd = $random(seed);
    nbr_reg <= rnd[3:0];
    nbr_op_n <= rnd[7:4];
    nbr_cin_n <= rnd[8];
    repeat (7) @(posedge ref_clk);
    #1;
    e = predict(top, {bit2, bit1, bit0}, r, dn);
    check("carry_out_n", {7'h0, carry_out_n}, {7'h0, e[6]});
    check("gen_ovf_n", {7'h0, gen_ovf_n}, {7'h0, e[4]});
    check("sum", {4'h0, sum}, {4'h0, e[3:0]});
    if (!e[7])
    begin
      check("prop_neg_n", {7'h0, prop_neg_n}, {7'h0, e[5]});
    end
  endtask : apply
  // -----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // -----------------------------------------------------------------
  task automatic summarize;
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial
  begin
    seed = 16796;
    n_errors = 0;
    tests_run = 0;
    srst = 1'b1;
    {top_sel, bit1, bit2, nbr_cin_n} = 4'h1;
    {operand_n, reg_op, nbr_reg, nbr_op_n} = 16'hF000;
    repeat (4) @(posedge ref_clk);
    #1;
    check("reset", {1'b0, carry_out_n, prop_neg_n, gen_ovf_n, sum}, 8'h70);
    @(posedge ref_clk);
    srst <= 1'b0;
    // Every bit one and two pair with bit zero from the neighbour, both slice positions, carry, overflow and zero-operand corners.
    for (int k = 0; k < 16; k++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        apply(k[3], k[1:0], corners[c][7:4], corners[c][3:0]);
      end
    end
    for (int n = 0; n < 200; n++)
    begin
      rnd = $random(seed);
      apply(rnd[0], rnd[2:1], rnd[6:3], rnd[10:7]);
    end
    summarize();
  end
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : scx_slice_tb
`default_nettype wire
